/* File: hw/bidio_top.v */
// Design decisions made here: the APB register port and the register addresses.
`include "bidio_consts.vh"

// ==========================================================
// general purpose ports c and e behind an apb slave
module bidio_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // configuration straps, static, caught after reset release
  input wire cfg_ccu2_pin_select,
  input wire cfg_reset_pin_enable,
  input wire cfg_port_e_present,
  // port c pads
  input wire [7:0] port_c_pin_i,
  output wire [7:0] port_c_pin_o,
  output wire [7:0] port_c_pin_oe,
  // port c peripheral overrides
  input wire [7:0] periph_c_ovr_en,
  input wire [7:0] periph_c_ovr_drive,
  input wire [7:0] periph_c_ovr_val,
  output reg [7:0] periph_c_in,
  // capture/compare unit 2
  input wire ccu2_out_en,
  input wire ccu2_out_val,
  output reg ccu2_in,
  // port e pads
  input wire [2:0] port_e_low_pins_i,
  output wire [2:0] port_e_low_pins_o,
  output wire [2:0] port_e_low_pins_oe,
  input wire port_e_pin3_i,
  // port e side functions
  output reg master_clear_n,
  output reg [3:0] psp_ctrl,
  output reg [2:0] port_e_analog_sel
);

  // ==========================================================
  // state
  reg [7:0] port_c_direction_q;
  reg [7:0] port_c_output_latch_q;
  reg [2:0] port_e_direction_q;
  reg [2:0] port_e_output_latch_q;
  reg [3:0] psp_ctrl_q;
  reg [2:0] port_e_analog_q;
  reg ccu2_pin_select_q;
  reg reset_pin_enable_q;
  reg port_e_present_q;
  reg cfg_taken_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire [7:0] c_sync;
  wire [3:0] e_sync;
  wire [7:0] c_ovr_en;
  wire [7:0] c_ovr_drive;
  wire [7:0] c_ovr_val;
  wire [2:0] e_dir_eff;
  wire [11:0] word_addr;
  wire access;
  wire commit;
  wire wr;
  wire [7:0] port_c_data_rd;
  wire [3:0] port_e_data_rd;
  wire pin3_is_port;
  // address decode and write strobes
  wire misaligned;
  wire hit_c_data;
  wire hit_c_latch;
  wire hit_c_dir;
  wire hit_e_data;
  wire hit_e_latch;
  wire hit_e_dir;
  wire hit_e_analog;
  wire hit_config;
  wire mapped;
  wire refused;
  wire wr_c_latch;
  wire wr_c_dir;
  wire wr_e_latch;
  wire wr_e_dir;
  wire wr_e_analog;

  // ==========================================================
  // apb handshake
  // one wait state: pready rises on the second access cycle
  assign access = psel & penable;
  assign commit = access & pready;
  // a refused write must never reach a register
  assign wr = commit & pwrite & ~refused;
  assign word_addr = {paddr[11:2], 2'b00};

  // answer registered; prdata stands until the next access, pslverr clears once access drops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        // writes and refused reads answer zero, never stale data
        prdata <= (pwrite | err_d) ? 32'h0000_0000 : rdata_d;
        pslverr <= err_d;
      end else if (!access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // address decode
  // each mapped word address hits exactly one register; a byte
  // address off a word boundary or an unmapped word is refused
  assign misaligned = (paddr[1:0] != 2'b00);
  assign hit_c_data = (word_addr == `BIDIO_OFF_C_DATA);
  assign hit_c_latch = (word_addr == `BIDIO_OFF_C_LATCH);
  assign hit_c_dir = (word_addr == `BIDIO_OFF_C_DIR);
  assign hit_e_data = (word_addr == `BIDIO_OFF_E_DATA);
  assign hit_e_latch = (word_addr == `BIDIO_OFF_E_LATCH);
  assign hit_e_dir = (word_addr == `BIDIO_OFF_E_DIR);
  assign hit_e_analog = (word_addr == `BIDIO_OFF_E_ANALOG);
  assign hit_config = (word_addr == `BIDIO_OFF_CONFIG);
  assign mapped = hit_c_data | hit_c_latch | hit_c_dir | hit_e_data |
    hit_e_latch | hit_e_dir | hit_e_analog | hit_config;
  assign refused = misaligned | ~mapped;

  // ==========================================================
  // write strobes
  // data and latch offsets load the same latch; the config word
  // has no strobe, so writes to it fall away silently
  assign wr_c_latch = wr & (hit_c_data | hit_c_latch);
  assign wr_c_dir = wr & hit_c_dir;
  assign wr_e_latch = wr & (hit_e_data | hit_e_latch);
  assign wr_e_dir = wr & hit_e_dir;
  assign wr_e_analog = wr & hit_e_analog;

  // ==========================================================
  // strap capture
  // straps are sampled once, one edge after release, so an
  // asynchronous reset never loads a port value
  // a strap that moves later waits for the next reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_taken_q <= 1'b0;
      ccu2_pin_select_q <= `BIDIO_RST_CCU2_SEL;
      reset_pin_enable_q <= `BIDIO_RST_MCLR_EN;
      port_e_present_q <= `BIDIO_RST_E_PRESENT;
    end else if (!cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      ccu2_pin_select_q <= cfg_ccu2_pin_select;
      reset_pin_enable_q <= cfg_reset_pin_enable;
      port_e_present_q <= cfg_port_e_present;
    end
  end

  // ==========================================================
  // pad input synchronisers
  // three flops and a filter: a pad change shows four edges later,
  // the price of rejecting a one-cycle disagreement
  // pin levels sampled
  bidio_sync3 #(.W(8)) u_sync_c (
    .pclk(pclk),
    .presetn(presetn),
    .async_i(port_c_pin_i),
    .level_q(c_sync)
  );

  bidio_sync3 #(.W(4)) u_sync_e (
    .pclk(pclk),
    .presetn(presetn),
    .async_i({port_e_pin3_i, port_e_low_pins_i}),
    .level_q(e_sync)
  );

  // ==========================================================
  // port c registers
  // reset to inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_direction_q <= `BIDIO_RST_C_DIR;
      port_c_output_latch_q <= `BIDIO_RST_C_LATCH;
    end else begin
      // latch offset loads the same latch
      if (wr_c_latch) begin
        port_c_output_latch_q <= pwdata[7:0];
      end
      // direction is stored as written, overrides never touch it
      if (wr_c_dir) begin
        port_c_direction_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // port e registers
  // reset to analog inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_direction_q <= `BIDIO_RST_E_DIR;
      port_e_output_latch_q <= `BIDIO_RST_E_LATCH;
      psp_ctrl_q <= `BIDIO_RST_PSP;
      port_e_analog_q <= `BIDIO_RST_E_ANALOG;
    end else begin
      // data and latch writes share the latch
      if (wr_e_latch) begin
        port_e_output_latch_q <= pwdata[2:0];
      end
      // bit 3 has no direction flop: pin3 is input only
      if (wr_e_dir) begin
        port_e_direction_q <= pwdata[2:0];
        psp_ctrl_q <= pwdata[7:4];
      end
      if (wr_e_analog) begin
        port_e_analog_q <= pwdata[2:0];
      end
    end
  end

  // ==========================================================
  // read path
  // analog pins read zero; pin3 readable only as port
  assign pin3_is_port = ~reset_pin_enable_q;
  // a data read shows the filtered pad, even on a driven pin, so
  // a shorted output reads back wrong
  // data reads return pad levels
  assign port_c_data_rd = c_sync;
  assign port_e_data_rd = port_e_present_q ?
    {e_sync[3] & pin3_is_port, e_sync[2:0] & ~port_e_analog_q} : 4'h0;

  // read mux; unmapped or misaligned offsets answer with pslverr
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = refused;
    case (word_addr)
      `BIDIO_OFF_C_DATA: rdata_d[7:0] = port_c_data_rd;
      `BIDIO_OFF_C_LATCH: rdata_d[7:0] = port_c_output_latch_q;
      `BIDIO_OFF_C_DIR: rdata_d[7:0] = port_c_direction_q;
      `BIDIO_OFF_E_DATA: rdata_d[3:0] = port_e_data_rd;
      `BIDIO_OFF_E_LATCH: rdata_d[2:0] = port_e_output_latch_q;
      `BIDIO_OFF_E_DIR: rdata_d[7:0] = {psp_ctrl_q, 1'b0, port_e_direction_q};
      `BIDIO_OFF_E_ANALOG: rdata_d[2:0] = port_e_analog_q;
      `BIDIO_OFF_CONFIG: begin
        rdata_d[`BIDIO_CFG_CCU2_SEL_BIT] = ccu2_pin_select_q;
        rdata_d[`BIDIO_CFG_E_PRESENT_BIT] = port_e_present_q;
        rdata_d[`BIDIO_CFG_MCLR_EN_BIT] = reset_pin_enable_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // port c pad drivers
  // override inputs share this clock and need no synchroniser
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_port_c
      if (gi == `BIDIO_CCU2_PIN) begin : g_ccu2
        // pin1 owned by capture unit 2 when selected
        assign c_ovr_en[gi] = periph_c_ovr_en[gi] | ccu2_pin_select_q;
        assign c_ovr_drive[gi] = ccu2_pin_select_q ?
          (ccu2_out_en | (periph_c_ovr_en[gi] & periph_c_ovr_drive[gi])) :
          periph_c_ovr_drive[gi];
        assign c_ovr_val[gi] = (ccu2_pin_select_q & ccu2_out_en) ?
          ccu2_out_val : periph_c_ovr_val[gi];
      end else begin : g_plain
        assign c_ovr_en[gi] = periph_c_ovr_en[gi];
        assign c_ovr_drive[gi] = periph_c_ovr_drive[gi];
        assign c_ovr_val[gi] = periph_c_ovr_val[gi];
      end
      bidio_pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .dir_input(port_c_direction_q[gi]),
        .latch_val(port_c_output_latch_q[gi]),
        .ovr_en(c_ovr_en[gi]),
        .ovr_drive(c_ovr_drive[gi]),
        .ovr_val(c_ovr_val[gi]),
        .pin_o_q(port_c_pin_o[gi]),
        .pin_oe_q(port_c_pin_oe[gi])
      );
    end
  endgenerate

  // ==========================================================
  // port e pad drivers
  // direction ignores analog select; is software's care
  // absent port never drives
  // floating pads are safe whatever the board ties them to
  assign e_dir_eff = port_e_present_q ? port_e_direction_q : 3'h7;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_port_e
      bidio_pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .dir_input(e_dir_eff[gi]),
        .latch_val(port_e_output_latch_q[gi]),
        .ovr_en(1'b0),
        .ovr_drive(1'b0),
        .ovr_val(1'b0),
        .pin_o_q(port_e_low_pins_o[gi]),
        .pin_oe_q(port_e_low_pins_oe[gi])
      );
    end
  endgenerate

  // ==========================================================
  // side outputs
  // pin3 becomes master clear; port input only if off
  // the clear request is only exported; the core decides what it resets
  // and the strap guard keeps it quiet until the straps are caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_clear_n <= 1'b1;
      psp_ctrl <= `BIDIO_RST_PSP;
      port_e_analog_sel <= `BIDIO_RST_E_ANALOG;
      periph_c_in <= 8'h00;
      ccu2_in <= 1'b0;
    end else begin
      // low only while enabled and pin held low
      master_clear_n <= ~(reset_pin_enable_q & cfg_taken_q & ~e_sync[3]);
      psp_ctrl <= psp_ctrl_q;
      port_e_analog_sel <= port_e_analog_q;
      periph_c_in <= c_sync;
      ccu2_in <= ccu2_pin_select_q & c_sync[`BIDIO_CCU2_PIN];
    end
  end

endmodule // bidio_top

/* File: hw/bidio_consts.vh */
`ifndef BIDIO_CONSTS_VH
`define BIDIO_CONSTS_VH

// ==========================================================
// register byte offsets
`define BIDIO_OFF_C_DATA 12'h000
`define BIDIO_OFF_C_LATCH 12'h004
`define BIDIO_OFF_C_DIR 12'h008
`define BIDIO_OFF_E_DATA 12'h00C
`define BIDIO_OFF_E_LATCH 12'h010
`define BIDIO_OFF_E_DIR 12'h014
`define BIDIO_OFF_E_ANALOG 12'h018
`define BIDIO_OFF_CONFIG 12'h01C

// ==========================================================
// reset values
`define BIDIO_RST_C_DIR 8'hFF
`define BIDIO_RST_C_LATCH 8'h00
`define BIDIO_RST_E_DIR 3'h7
`define BIDIO_RST_E_LATCH 3'h0
`define BIDIO_RST_E_ANALOG 3'h7
`define BIDIO_RST_PSP 4'h0
`define BIDIO_RST_CCU2_SEL 1'b1
`define BIDIO_RST_MCLR_EN 1'b1
`define BIDIO_RST_E_PRESENT 1'b1

// ==========================================================
// field positions
`define BIDIO_CFG_CCU2_SEL_BIT 0
`define BIDIO_CFG_E_PRESENT_BIT 1
`define BIDIO_CFG_MCLR_EN_BIT 7
`define BIDIO_PSP_LSB 4
`define BIDIO_CCU2_PIN 1

`endif

/* File: hw/bidio_sync3.v */
// ==========================================================
// three-stage input synchroniser with agreement filter
module bidio_sync3 #(
  parameter W = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // asynchronous levels in, filtered levels out
  input wire [W-1:0] async_i,
  output reg [W-1:0] level_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree;

  // first stage feeds only the second stage
  assign agree = ~(s2_q ^ s3_q);

  // chain plus filter; a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (agree & s3_q) | (~agree & level_q);
    end
  end

endmodule // bidio_sync3

/* File: hw/bidio_pin_cell.v */
// ==========================================================
// one pin driver: direction, latch and peripheral override
module bidio_pin_cell (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // software state
  input wire dir_input,
  input wire latch_val,
  // peripheral override
  input wire ovr_en,
  input wire ovr_drive,
  input wire ovr_val,
  // pad side
  output reg pin_o_q,
  output reg pin_oe_q
);

  reg pin_o_d;
  reg pin_oe_d;

  always @* begin
    pin_o_d = latch_val;
    pin_oe_d = ~dir_input;
    if (ovr_en) begin
      pin_oe_d = ovr_drive;
      pin_o_d = ovr_drive ? ovr_val : latch_val;
    end
  end

  // driver registered; reset floats the pad
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

endmodule // bidio_pin_cell

/* File: tb/bidio_pads.sv */
// ====================
// board pads
module bidio_pads (
  // block drive
  input wire logic [7:0] c_o,
  input wire logic [7:0] c_oe,
  input wire logic [2:0] e_o,
  input wire logic [2:0] e_oe,
  // board side levels
  input wire logic [7:0] c_ext,
  input wire logic [2:0] e_ext,
  // resolved pad levels
  output logic [7:0] c_pad,
  output logic [2:0] e_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven pins win
  // a floating pin shows the board level, so a stuck enable reads wrong
  assign c_pad = (c_o & c_oe) | (c_ext & ~c_oe);
  assign e_pad = (e_o & e_oe) | (e_ext & ~e_oe);
endmodule // bidio_pads

/* File: tb/bidio_chk.sv */
// ====================
// port checker
module bidio_chk (
  // watched ports
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cfg_reset_pin_enable,
  input wire cfg_port_e_present,
  input wire [7:0] port_c_pin_oe,
  input wire [7:0] periph_c_ovr_en,
  input wire [7:0] periph_c_ovr_drive,
  input wire [2:0] port_e_low_pins_oe,
  input wire port_e_pin3_i,
  input wire master_clear_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed access
  wire acc = psel && penable && pready;
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; !pready ##1 pready; endsequence
  ans_time_a: assert property (setup_s |=> answer_s)
    else $error("answer not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  refuse_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not refused");
  // pin1 masked: the capture unit owns it
  c_dir_a: assert property (acc && pwrite && paddr == 12'h008 &&
    periph_c_ovr_en == 8'h00 ##1 periph_c_ovr_en == 8'h00 |=>
    (port_c_pin_oe & 8'hFD) == (~$past(pwdata, 2) & 8'hFD))
    else $error("port c enable not from direction");
  c_ovr_a: assert property (periph_c_ovr_en[0] |=> port_c_pin_oe[0] == $past(periph_c_ovr_drive[0]))
    else $error("override ignored");
  e_absent_a: assert property (acc && !pwrite && paddr == 12'h00C &&
    !cfg_port_e_present |-> prdata == 32'h0000_0000)
    else $error("absent port e reads nonzero");
  e_dir_a: assert property (acc && pwrite && paddr == 12'h014 &&
    cfg_port_e_present |=> ##1 port_e_low_pins_oe == ~$past(pwdata[2:0], 2))
    else $error("port e enable not from direction");
  mclr_on_a: assert property ((cfg_reset_pin_enable && !port_e_pin3_i) [*6] |-> !master_clear_n)
    else $error("master clear not asserted");
endmodule // bidio_chk

bind bidio_top bidio_chk bidio_chk_i (.*);

/* File: tb/tb_top.sv */
// ====================
// bench top
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, ccu2_in, master_clear_n;
  logic cfg_ccu2_pin_select = 1'b1, cfg_reset_pin_enable = 1'b1, cfg_port_e_present = 1'b1;
  logic ccu2_out_en = 1'b0, ccu2_out_val = 1'b0, port_e_pin3_i = 1'b0;
  logic [7:0] periph_c_ovr_en = '0, periph_c_ovr_drive = '0, periph_c_ovr_val = '0;
  logic [7:0] port_c_pin_i, port_c_pin_o, port_c_pin_oe, periph_c_in;
  logic [2:0] port_e_low_pins_i, port_e_low_pins_o, port_e_low_pins_oe, port_e_analog_sel;
  logic [3:0] psp_ctrl;
  int miscompares = 0, comparisons = 0;
  bidio_top bidio_top_i (.*);
  bidio_pads bidio_pads_i (.c_o(port_c_pin_o), .c_oe(port_c_pin_oe), .e_o(port_e_low_pins_o),
    .e_oe(port_e_low_pins_oe), .c_ext(8'h5A), .e_ext(3'h2), .c_pad(port_c_pin_i),
    .e_pad(port_e_low_pins_i));
  initial forever #10 pclk = ~pclk;
  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer, held until pready; bounded wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, err);
  endtask
  task automatic do_reset(input logic pres, input logic rpen, input logic pin3);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg_port_e_present <= pres;
    cfg_reset_pin_enable <= rpen;
    port_e_pin3_i <= pin3;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_reset();
    chk(port_c_pin_oe, 8'h00);
    rd(12'h008, 32'h0000_00FF);
    rd(12'h004, 32'h0000_0000);
    rd(12'h014, 32'h0000_0007);
    rd(12'h018, 32'h0000_0007);
    rd(12'h01C, 32'h0000_0083);
  endtask
  task automatic t_port_c();
    wr(12'h004, 32'h0000_00A5);
    wr(12'h008, 32'h0000_000F);
    repeat (2) @(negedge pclk);
    chk(port_c_pin_oe, 8'hF0);
    chk(port_c_pin_o & port_c_pin_oe, 8'hA0);
    wr(12'h000, 32'h0000_003C);
    rd(12'h004, 32'h0000_003C);
    // pad reads lag by the input filter
    repeat (8) @(negedge pclk);
    rd(12'h000, 32'h0000_003A);
    chk(periph_c_in, 8'h3A);
  endtask
  task automatic t_override();
    @(posedge pclk);
    periph_c_ovr_en <= 8'h11;
    periph_c_ovr_drive <= 8'h01;
    periph_c_ovr_val <= 8'h01;
    ccu2_out_en <= 1'b1;
    ccu2_out_val <= 1'b1;
    repeat (2) @(negedge pclk);
    chk(port_c_pin_oe, 8'hE3);
    chk(port_c_pin_o & port_c_pin_oe, 8'h23);
    rd(12'h008, 32'h0000_000F);
    chk(ccu2_in, 1'b1);
    periph_c_ovr_en <= 8'h00;
    ccu2_out_en <= 1'b0;
  endtask
  task automatic t_port_e();
    wr(12'h010, 32'h0000_0005);
    wr(12'h018, 32'h0000_0002);
    wr(12'h014, 32'h0000_00A2);
    repeat (2) @(negedge pclk);
    chk(port_e_low_pins_oe, 3'h5);
    chk(port_e_low_pins_o & port_e_low_pins_oe, 3'h5);
    chk(psp_ctrl, 4'hA);
    rd(12'h014, 32'h0000_00A2);
    rd(12'h00C, 32'h0000_0005);
    wr(12'h018, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0007);
    chk(port_e_analog_sel, 3'h0);
    chk(master_clear_n, 1'b0);
  endtask
  // refused and read-only accesses
  task automatic t_refused();
    rd(12'h020, 32'h0000_0000, 1'b1);
    rd(12'h002, 32'h0000_0000, 1'b1);
    wr(12'h006, 32'h0000_00FF);
    rd(12'h004, 32'h0000_003C);
    wr(12'h01C, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0083);
  endtask
  task automatic t_strap(input logic pres, input logic [31:0] e_exp, input logic [31:0] c_exp);
    do_reset(pres, 1'b0, 1'b1);
    repeat (6) @(negedge pclk);
    rd(12'h00C, e_exp);
    rd(12'h01C, c_exp);
    chk(master_clear_n, 1'b1);
    wr(12'h018, 32'h0000_0000);
    wr(12'h014, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk(port_e_low_pins_oe, pres ? 3'h7 : 3'h0);
  endtask
  initial begin
    do_reset(1'b1, 1'b1, 1'b0);
    t_reset();
    t_port_c();
    t_override();
    t_port_e();
    t_refused();
    t_strap(1'b0, 32'h0000_0000, 32'h0000_0001);
    t_strap(1'b1, 32'h0000_0008, 32'h0000_0003);
    end_sim();
  end
endmodule // tb_top
